// ===== hw/usb_hs_chirp_pkg.sv
package usb_hs_chirp_pkg;

    // clock rate of this block and of the reference chirp clock
    localparam int unsigned CLK_MHZ = 100;
    localparam int unsigned REF_MHZ = 60;

    // line state encodings seen from the transceiver
    localparam logic [1:0] LINE_SE0 = 2'h0;
    localparam logic [1:0] LINE_J = 2'h1;
    localparam logic [1:0] LINE_K = 2'h2;

    // transceiver operating modes
    localparam logic [1:0] OPMODE_NORMAL = 2'h0;
    localparam logic [1:0] OPMODE_RAW = 2'h2; // no bit stuffing, no nrzi
    localparam logic [7:0] CHIRP_TX_DATA = 8'h00;

    // speed and termination select levels
    localparam logic SEL_HS = 1'b0;
    localparam logic SEL_FS = 1'b1;

    // fs se0 longer than this is a reset (least time, rounded up)
    localparam int unsigned T_SE0_RESET_NS = 2500;
    localparam int unsigned SE0_RESET_CYC = (T_SE0_RESET_NS * CLK_MHZ + 999) / 1000;
    // hs idle time before reverting to full speed (least time)
    localparam int unsigned T_IDLE_REVERT_US = 3000;
    localparam int unsigned IDLE_REVERT_CYC = T_IDLE_REVERT_US * CLK_MHZ;
    // line sample point after reverting (least time of the window)
    localparam int unsigned T_REVERT_SAMPLE_US = 100;
    localparam int unsigned REVERT_SAMPLE_CYC = T_REVERT_SAMPLE_US * CLK_MHZ;
    // device chirp length: reference cycle count rescaled to this clock
    localparam int unsigned CHIRP_REF_CYC = 66000;
    localparam int unsigned CHIRP_CYC = (CHIRP_REF_CYC * CLK_MHZ + REF_MHZ - 1) / REF_MHZ;
    // wait for host chirp before falling back to full speed (least time)
    localparam int unsigned T_WAIT_FS_US = 1000;
    localparam int unsigned WAIT_FS_CYC = T_WAIT_FS_US * CLK_MHZ;
    // a host chirp k or j must stand this long to be counted
    localparam int unsigned T_CHIRP_FILT_NS = 2500;
    localparam int unsigned CHIRP_FILT_CYC = (T_CHIRP_FILT_NS * CLK_MHZ + 999) / 1000;
    // host k-j pairs needed to settle in high speed
    localparam int unsigned KJ_PAIRS = 6;

    // register byte offsets
    localparam logic [7:0] REG_CONTROL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;

    // control register fields
    localparam int CTL_CHIRP_DONE_EN = 0;
    localparam int CTL_SIE_GROUP_EN = 1;
    localparam int CTL_DEVICE_GROUP_EN = 2;
    localparam int CTL_WAKE_ALL = 3;
    localparam int CTL_WAKE_DEVICE = 4;
    localparam int CTL_RESTART = 5; // self-clearing, reads zero
    localparam logic [4:0] CONTROL_RESET = 5'h00;

    // status register fields
    localparam int STS_CHIRP_DONE = 0; // write one to clear
    localparam int STS_FULL_SPEED = 1;
    localparam int STS_CHIRP_GO = 2;
    localparam int STS_STATE_LSB = 4; // state code, 3 bits

    // handshake machine states
    typedef enum logic [2:0] {
        ST_FS,
        ST_SUSPEND,
        ST_HS,
        ST_REVERT,
        ST_CHIRP_K,
        ST_WAIT_HOST
    } hs_state_t;

    // control bundle toward the transceiver
    typedef struct packed {
        logic transceiver_speed_select;
        logic termination_select;
        logic [1:0] transceiver_operating_mode;
        logic tx_valid;
        logic [7:0] tx_data;
    } xcvr_ctrl_t;

endpackage : usb_hs_chirp_pkg

// ===== hw/usb_hs_chirp_handshake.sv
// The Wishbone interface to the registers and the address map were chosen for this implementation.
`timescale 1ns/1ps
// Operation
// [R1] in suspend, an se0 on the bus starts the handshake at once
// [R2] at full speed, se0 longer than 2.5 us is a reset, then handshake
// [R3] after 3.0 ms hs idle, switch selects and termination to full speed
// [R4] 100 to 875 us after reverting sample line: j suspend, se0 handshake
// [R5] handshake starts with full speed selects, pull-up on, hs termination off
// [R6] chirp: chirp_go set, raw opmode, zero data, hs transceiver select
// [R7] chirp k starts well before 6.0 ms after reset start
// [R8] chirp k lasts the rescaled 66000 reference cycles, at least 1 ms
// [R9] chirp k ends before 7.0 ms, then wait for host chirp
// [R10] host begins its chirp k within 100 us of device chirp end
// [R11] host alternates chirp k and j until reset ends
// [R12] no host chirp: back to full speed, clear chirp_go, set flags
// [R13] six host k-j pairs: hs termination, clear chirp_go and fs flag
// [R14] interrupt when chirp done flag and all three enables are set
// [R15] host holds bus reset at least 10 ms
// [R16] counted host chirps are bus activity for the suspend timer
// [R17] with hs termination line monitor shows j on activity, se0 otherwise
// [R18] firmware sets a wake bit so the clock runs before handshake
// [R19] hs switch and done flag come within 500 us of recognition
// [R20] all intervals are cycle counters; restart returns machine to idle
module usb_hs_chirp_handshake
    import usb_hs_chirp_pkg::*;
#(
    parameter int unsigned TIMER_W = 20,
    parameter int unsigned IDLE_REVERT_CYCLES = IDLE_REVERT_CYC,
    parameter int unsigned REVERT_SAMPLE_CYCLES = REVERT_SAMPLE_CYC,
    parameter int unsigned CHIRP_CYCLES = CHIRP_CYC,
    parameter int unsigned WAIT_FS_CYCLES = WAIT_FS_CYC
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic wb_cyc,
    input wire logic wb_stb,
    input wire logic wb_we,
    input wire logic [7:0] wb_adr,
    input wire logic [3:0] wb_sel,
    input wire logic [31:0] wb_dat_w,
    output logic [31:0] wb_dat_r,
    output logic wb_ack,
    input wire logic [1:0] line_state_raw,
    input wire logic bus_activity,
    output xcvr_ctrl_t xcvr,
    output logic [1:0] line_state_monitor,
    output logic interrupt_request_out,
    output logic clock_wake_request
);

    localparam logic [TIMER_W-1:0] SE0_LIM = TIMER_W'(SE0_RESET_CYC);
    localparam logic [TIMER_W-1:0] IDLE_LIM = TIMER_W'(IDLE_REVERT_CYCLES);
    localparam logic [TIMER_W-1:0] SAMPLE_LIM = TIMER_W'(REVERT_SAMPLE_CYCLES);
    localparam logic [TIMER_W-1:0] CHIRP_LIM = TIMER_W'(CHIRP_CYCLES);
    localparam logic [TIMER_W-1:0] WAIT_LIM = TIMER_W'(WAIT_FS_CYCLES);
    localparam logic [TIMER_W-1:0] FILT_LIM = TIMER_W'(CHIRP_FILT_CYC);
    localparam logic [2:0] KJ_LIM = 3'(KJ_PAIRS);

    hs_state_t state;
    hs_state_t next_state;
    logic [1:0] line_meta;
    logic [1:0] line_sync;
    logic [1:0] line_prev;
    logic act_meta;
    logic act_sync;
    logic [TIMER_W-1:0] timer;
    logic [TIMER_W-1:0] filt_timer;
    logic [1:0] chirp_last;
    logic [2:0] kj_count;
    logic [4:0] control;
    logic restart;
    logic chirp_go;
    logic full_speed_indication;
    logic chirp_done_flag;

    // two-stage synchronisers for transceiver line state and activity
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            line_meta <= LINE_J;
            line_sync <= LINE_J;
            act_meta <= 1'b0;
            act_sync <= 1'b0;
        end else begin
            line_meta <= line_state_raw;
            line_sync <= line_meta;
            act_meta <= bus_activity;
            act_sync <= act_meta;
        end
    end

    // host chirp filter: a k or j is accepted after standing long enough
    wire line_changed = line_sync != line_prev;
    wire is_kj = (line_sync == LINE_K) || (line_sync == LINE_J);
    wire chirp_seen = (state == ST_WAIT_HOST) && is_kj && !line_changed
        && (filt_timer == FILT_LIM) && (line_sync != chirp_last);
    wire kj_pair = chirp_seen && (line_sync == LINE_J) && (chirp_last == LINE_K);
    wire kj_done = kj_pair && (kj_count == KJ_LIM - 3'h1); // [R13]
    // in hs every host chirp k or j step on the line counts as activity
    wire chirp_step = is_kj && line_changed;
    wire activity = act_sync || chirp_seen || chirp_step; // [R16]

    // interval timer: restarts on state change, on line change or activity in fs and
    // on any activity in hs
    wire timer_clear = (next_state != state)
        || ((state == ST_FS) && (line_changed || act_sync))
        || ((state == ST_HS) && activity); // [R16] [R20]

    // next state of the handshake machine
    always_comb begin
        next_state = state;
        case (state)
            ST_FS: begin
                if (line_sync == LINE_SE0 && !line_changed && timer >= SE0_LIM) begin
                    next_state = ST_CHIRP_K; // [R2]
                end else if (line_sync == LINE_J && !line_changed && timer >= IDLE_LIM) begin
                    next_state = ST_SUSPEND;
                end
            end
            ST_SUSPEND: begin
                if (line_sync == LINE_SE0) begin
                    next_state = ST_CHIRP_K; // [R1]
                end else if (line_sync != LINE_J) begin
                    next_state = ST_FS;
                end
            end
            ST_HS: begin
                if (timer >= IDLE_LIM) begin
                    next_state = ST_REVERT; // [R3]
                end
            end
            ST_REVERT: begin
                if (timer >= SAMPLE_LIM) begin
                    if (line_sync == LINE_SE0) begin
                        next_state = ST_CHIRP_K; // [R4]
                    end else if (line_sync == LINE_J) begin
                        next_state = ST_SUSPEND; // [R4]
                    end else begin
                        next_state = ST_FS;
                    end
                end
            end
            ST_CHIRP_K: begin
                if (timer >= CHIRP_LIM) begin
                    next_state = ST_WAIT_HOST; // [R8] [R9]
                end
            end
            ST_WAIT_HOST: begin
                if (kj_done) begin
                    next_state = ST_HS; // [R13] [R19]
                end else if (timer >= WAIT_LIM) begin
                    next_state = ST_FS; // [R12]
                end
            end
            default: begin
                next_state = ST_FS;
            end
        endcase
        if (restart) begin
            next_state = ST_FS; // [R20]
        end
    end

    // state register and interval counters
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state <= ST_FS;
            timer <= '0;
            line_prev <= LINE_J;
        end else begin
            state <= next_state;
            timer <= timer_clear ? '0 : timer + 1'b1; // [R20]
            line_prev <= line_sync;
        end
    end

    // host chirp stability counter and k-j pair counter
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            filt_timer <= '0;
            chirp_last <= LINE_SE0;
            kj_count <= 3'h0;
        end else if (state != ST_WAIT_HOST) begin
            filt_timer <= '0;
            chirp_last <= LINE_SE0;
            kj_count <= 3'h0;
        end else begin
            filt_timer <= (line_changed || filt_timer == FILT_LIM) ? '0 : filt_timer + 1'b1;
            chirp_last <= chirp_seen ? line_sync : chirp_last;
            kj_count <= kj_pair ? kj_count + 3'h1 : kj_count;
        end
    end

    // transceiver controls registered from the next state
    wire next_hs_term = (next_state == ST_HS);
    wire next_chirping = (next_state == ST_CHIRP_K);
    wire next_hs_select = next_chirping || (next_state == ST_WAIT_HOST) || next_hs_term;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            xcvr.transceiver_speed_select <= SEL_FS;
            xcvr.termination_select <= SEL_FS;
            xcvr.transceiver_operating_mode <= OPMODE_NORMAL;
            xcvr.tx_valid <= 1'b0;
            xcvr.tx_data <= 8'h00;
        end else begin
            // fs selects and pull-up everywhere outside chirp, host wait and hs
            xcvr.transceiver_speed_select <= next_hs_select ? SEL_HS : SEL_FS; // [R3] [R5] [R6]
            xcvr.termination_select <= next_hs_term ? SEL_HS : SEL_FS; // [R3] [R5] [R13]
            xcvr.transceiver_operating_mode <= next_chirping ? OPMODE_RAW : OPMODE_NORMAL; // [R6]
            xcvr.tx_valid <= next_chirping; // [R6] [R7]
            xcvr.tx_data <= CHIRP_TX_DATA; // [R6]
        end
    end

    // line monitor: synchronised line at fs termination, activity view at hs
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            line_state_monitor <= LINE_J;
        end else if (xcvr.termination_select == SEL_HS) begin
            line_state_monitor <= act_sync ? LINE_J : LINE_SE0; // [R17]
        end else begin
            line_state_monitor <= line_sync;
        end
    end

    // wishbone decode
    wire bus_req = wb_cyc && wb_stb && !wb_ack;
    wire bus_wr = bus_req && wb_we;
    wire hit_control = (wb_adr == REG_CONTROL);
    wire hit_status = (wb_adr == REG_STATUS);
    wire wr_control = bus_wr && hit_control && wb_sel[0];
    wire clr_done = bus_wr && hit_status && wb_sel[0] && wb_dat_w[STS_CHIRP_DONE];
    wire [31:0] status_word = {25'h0, 3'(state), 1'b0, chirp_go,
        full_speed_indication, chirp_done_flag};
    wire [31:0] read_word = hit_control ? {27'h0, control}
        : (hit_status ? status_word : 32'h0);

    // handshake result flags; a set wins over a software clear
    wire done_fs = (state == ST_WAIT_HOST) && (next_state == ST_FS) && !restart;
    wire done_hs = (state == ST_WAIT_HOST) && (next_state == ST_HS);
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            chirp_go <= 1'b0;
            full_speed_indication <= 1'b1;
            chirp_done_flag <= 1'b0;
        end else begin
            chirp_go <= next_chirping; // [R6] [R12] [R13]
            full_speed_indication <= done_fs ? 1'b1
                : (done_hs ? 1'b0 : full_speed_indication); // [R12] [R13]
            chirp_done_flag <= done_fs || done_hs
                || (chirp_done_flag && !clr_done); // [R12] [R13] [R19]
        end
    end

    // register storage and bus answer, one wait state
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            control <= CONTROL_RESET;
            restart <= 1'b0;
            wb_ack <= 1'b0;
            wb_dat_r <= 32'h0;
        end else begin
            control <= wr_control ? wb_dat_w[4:0] : control;
            restart <= wr_control && wb_dat_w[CTL_RESTART];
            wb_ack <= bus_req;
            wb_dat_r <= bus_req ? read_word : 32'h0;
        end
    end

    // interrupt chain and clock wake request
    assign interrupt_request_out = chirp_done_flag && control[CTL_CHIRP_DONE_EN]
        && control[CTL_SIE_GROUP_EN] && control[CTL_DEVICE_GROUP_EN]; // [R14]
    assign clock_wake_request = control[CTL_WAKE_ALL] || control[CTL_WAKE_DEVICE]; // [R18]

endmodule : usb_hs_chirp_handshake

// ===== bench/usb_hs_chirp_chk.sv
`timescale 1ns/1ps
module usb_hs_chirp_chk
    import usb_hs_chirp_pkg::*;
#(
    parameter int unsigned IDLE_REVERT_CYCLES = 400,
    parameter int unsigned CHIRP_CYCLES = 300
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic wb_cyc,
    input wire logic wb_stb,
    input wire logic wb_we,
    input wire logic [7:0] wb_adr,
    input wire logic [3:0] wb_sel,
    input wire logic [31:0] wb_dat_w,
    input wire logic [31:0] wb_dat_r,
    input wire logic wb_ack,
    input wire logic [1:0] line_state_raw,
    input wire logic bus_activity,
    input wire xcvr_ctrl_t xcvr,
    input wire logic [1:0] line_state_monitor,
    input wire logic interrupt_request_out,
    input wire logic clock_wake_request
);
    logic [19:0] run;
    logic [19:0] se0_run;
    logic [19:0] idle_run;
    wire fs_sel = xcvr.transceiver_speed_select == SEL_FS && xcvr.termination_select == SEL_FS;
    wire hs_quiet = xcvr.termination_select == SEL_HS && !bus_activity;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // lengths of the chirp, of se0 at full speed and of silence at high speed
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            run <= 20'h0;
            se0_run <= 20'h0;
            idle_run <= 20'h0;
        end else begin
            run <= xcvr.tx_valid ? run + 20'h1 : 20'h0;
            se0_run <= (fs_sel && line_state_raw == LINE_SE0) ? se0_run + 20'h1 : 20'h0;
            idle_run <= hs_quiet ? idle_run + 20'h1 : 20'h0;
        end
    end
    // bus handshake, chirp drive, speed changes and line monitor
    property p_ack_pulse; wb_ack |=> !wb_ack; endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
    property p_ack_latency; wb_cyc && wb_stb && !wb_ack |=> wb_ack; endproperty
    a_ack_latency: assert property (p_ack_latency) else $error("ack missing");
    property p_dat_idle; !wb_ack |-> wb_dat_r == 32'h0; endproperty
    a_dat_idle: assert property (p_dat_idle) else $error("read data without ack");
    property p_chirp_drive; xcvr.tx_valid |-> xcvr.transceiver_speed_select == SEL_HS &&
        xcvr.transceiver_operating_mode == OPMODE_RAW && xcvr.tx_data == CHIRP_TX_DATA;
    endproperty
    a_chirp_drive: assert property (p_chirp_drive) else $error("bad chirp drive");
    property p_chirp_len; $fell(xcvr.tx_valid) |-> run == CHIRP_CYCLES + 1; endproperty
    a_chirp_len: assert property (p_chirp_len) else $error("chirp length wrong");
    property p_hs_entry; $fell(xcvr.termination_select) |-> !xcvr.tx_valid &&
        xcvr.transceiver_speed_select == SEL_HS; endproperty
    a_hs_entry: assert property (p_hs_entry) else $error("bad high speed entry");
    property p_fs_reset; se0_run <= 20'h10E; endproperty
    a_fs_reset: assert property (p_fs_reset) else $error("se0 reset not taken");
    property p_hs_revert; idle_run <= IDLE_REVERT_CYCLES + 8; endproperty
    a_hs_revert: assert property (p_hs_revert) else $error("no revert on idle");
    property p_mon_j; (!hs_quiet && xcvr.termination_select == SEL_HS)[*5] |->
        line_state_monitor == LINE_J; endproperty
    a_mon_j: assert property (p_mon_j) else $error("monitor not j on activity");
endmodule : usb_hs_chirp_chk

bind usb_hs_chirp_handshake usb_hs_chirp_chk #(.IDLE_REVERT_CYCLES(IDLE_REVERT_CYCLES),
    .CHIRP_CYCLES(CHIRP_CYCLES)) u_chk (.clk(clk), .rst(rst), .wb_cyc(wb_cyc),
    .wb_stb(wb_stb), .wb_we(wb_we), .wb_adr(wb_adr), .wb_sel(wb_sel), .wb_dat_w(wb_dat_w),
    .wb_dat_r(wb_dat_r), .wb_ack(wb_ack), .line_state_raw(line_state_raw),
    .bus_activity(bus_activity), .xcvr(xcvr), .line_state_monitor(line_state_monitor),
    .interrupt_request_out(interrupt_request_out), .clock_wake_request(clock_wake_request));

// ===== bench/usb_host_port_model.sv
`timescale 1ns/1ps
module usb_host_port_model
    import usb_hs_chirp_pkg::*;
#(
    parameter int unsigned CHIRP_BIT = 300,
    parameter int unsigned REPLY_DELAY = 30
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [1:0] host_mode,
    input wire xcvr_ctrl_t xcvr,
    output logic [1:0] line_state_raw,
    output logic bus_activity
);
    logic tx_seen;
    logic [19:0] cnt;
    // modes: 0 idle j, 1 reset by fs-only host, 2 reset by hs host, 3 hs idle
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tx_seen <= 1'b0;
            cnt <= 20'h0;
            bus_activity <= 1'b0;
            line_state_raw <= LINE_J;
        end else if (host_mode == 2'h0 || host_mode == 2'h3) begin
            tx_seen <= 1'b0;
            cnt <= 20'h0;
            bus_activity <= 1'b0;
            line_state_raw <= (host_mode == 2'h0) ? LINE_J : LINE_SE0;
        end else if (xcvr.tx_valid) begin
            tx_seen <= 1'b1;
            cnt <= 20'h0;
            line_state_raw <= LINE_K; // device chirp on the wire
        end else if (!tx_seen || host_mode == 2'h1) begin
            line_state_raw <= LINE_SE0;
        end else begin
            // prompt reply, then k and j alternate until reset ends
            cnt <= cnt + 20'h1;
            bus_activity <= cnt >= REPLY_DELAY;
            line_state_raw <= (cnt < REPLY_DELAY) ? LINE_SE0 :
                (((cnt - REPLY_DELAY) / CHIRP_BIT) % 2 == 1) ? LINE_J : LINE_K;
        end
    end
endmodule : usb_host_port_model

// ===== bench/usb_hs_chirp_handshake_test.sv
`timescale 1ns/1ps
module usb_hs_chirp_handshake_test import usb_hs_chirp_pkg::*;;
    localparam int unsigned IDLE = 400;
    localparam int unsigned SAMPLE = 50;
    localparam int unsigned CHIRP = 300;
    localparam int unsigned WAIT_FS = 4000;
    logic clk, rst, wb_cyc, wb_stb, wb_we, wb_ack;
    logic bus_activity, interrupt_request_out, clock_wake_request;
    logic [7:0] wb_adr;
    logic [3:0] wb_sel;
    logic [31:0] wb_dat_w, wb_dat_r, rd, r;
    logic [1:0] line_state_raw, line_state_monitor, host_mode;
    xcvr_ctrl_t xcvr;
    int miscompares, checks_done, n, i;

    usb_hs_chirp_handshake #(.IDLE_REVERT_CYCLES(IDLE), .REVERT_SAMPLE_CYCLES(SAMPLE),
        .CHIRP_CYCLES(CHIRP), .WAIT_FS_CYCLES(WAIT_FS)) DUT (.clk(clk), .rst(rst),
        .wb_cyc(wb_cyc), .wb_stb(wb_stb), .wb_we(wb_we), .wb_adr(wb_adr), .wb_sel(wb_sel),
        .wb_dat_w(wb_dat_w), .wb_dat_r(wb_dat_r), .wb_ack(wb_ack),
        .line_state_raw(line_state_raw), .bus_activity(bus_activity), .xcvr(xcvr),
        .line_state_monitor(line_state_monitor),
        .interrupt_request_out(interrupt_request_out),
        .clock_wake_request(clock_wake_request));
    usb_host_port_model host (.clk(clk), .rst(rst), .host_mode(host_mode), .xcvr(xcvr),
        .line_state_raw(line_state_raw), .bus_activity(bus_activity));

    always #5 clk = ~clk;

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : end_of_test

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
            miscompares++;
        end
    endtask : check

    // one classic cycle; read data lands in rd
    task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat,
        input logic [3:0] sel = 4'hF);
        int k;
        @(posedge clk);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_adr <= adr;
        wb_dat_w <= dat;
        wb_sel <= sel;
        k = 0;
        // ack and read data are taken at the rising edge that samples ack high
        do begin
            @(posedge clk);
            k++;
        end while (wb_ack !== 1'b1 && k < 20);
        check("ack", 32'h1, {31'h0, wb_ack});
        rd = wb_dat_r;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
    endtask : wb

    function automatic logic [31:0] sts(input logic f, fs, go, input logic [2:0] st);
        return {25'h0, st, 1'b0, go, fs, f};
    endfunction : sts

    function automatic bit cond(input int c);
        case (c)
            0: return xcvr.tx_valid === 1'b1;
            1: return xcvr.tx_valid === 1'b0;
            2: return xcvr.transceiver_speed_select === SEL_FS;
            3: return xcvr.termination_select === SEL_HS;
            default: return xcvr.termination_select === SEL_FS;
        endcase
    endfunction : cond

    // counts cycles until the event, bounded
    task automatic wait_for(input int c, input int limit);
        n = 0;
        while (!cond(c) && n < limit) begin
            @(negedge clk);
            n++;
        end
        check("event", 32'h1, {31'h0, cond(c)});
    endtask : wait_for

    initial begin
        repeat (60000) @(posedge clk);
        miscompares++;
        end_of_test();
    end

    initial begin
        {clk, wb_cyc, wb_stb, wb_we, wb_adr, wb_sel, wb_dat_w, host_mode} = '0;
        rst = 1'b1;
        miscompares = 0;
        checks_done = 0;
        r = $urandom(7);
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        wb(0, REG_STATUS, 0);
        check("status", sts(0, 1, 0, 0), rd);
        wb(0, 8'h08, 0);
        check("unmapped", 32'h0, rd);
        r = $urandom;
        wb(1, REG_CONTROL, {27'h0, r[4:0]});
        wb(1, 8'h08, 32'hFFFFFFFF);
        wb(1, REG_CONTROL, 32'h1F, 4'h0);
        wb(0, REG_CONTROL, 0);
        check("control", {27'h0, r[4:0]}, rd);
        check("wake", {31'h0, r[3] | r[4]}, {31'h0, clock_wake_request});
        $display("test registers done");
        repeat (IDLE + 20) @(posedge clk);
        wb(0, REG_STATUS, 0);
        check("suspend", sts(0, 1, 0, 1), rd);
        host_mode <= 2'h1;
        wait_for(0, 20);
        check("se0_in_suspend", 1, n <= 8);
        wait_for(1, CHIRP + 10);
        wait_for(2, WAIT_FS + 20);
        check("fs_fallback", 1, n >= WAIT_FS - 2 && n <= WAIT_FS + 8);
        @(posedge clk);
        host_mode <= 2'h0;
        wb(0, REG_STATUS, 0);
        check("status_fs", sts(1, 1, 0, 0), rd);
        for (i = 0; i < 8; i++) begin
            r = (i == 7) ? 32'h7 : $urandom;
            wb(1, REG_CONTROL, {29'h0, r[2:0]});
            check("irq", {31'h0, &r[2:0]}, {31'h0, interrupt_request_out});
        end
        wb(1, REG_STATUS, 32'h1);
        check("irq_clear", 32'h0, {31'h0, interrupt_request_out});
        $display("test fs host done");
        host_mode <= 2'h2;
        wait_for(0, 300);
        check("se0_in_fs", 1, n >= 250 && n <= 262);
        wb(0, REG_STATUS, 0);
        check("status_chirp", sts(0, 1, 1, 4), rd);
        wait_for(1, CHIRP + 10);
        wait_for(3, WAIT_FS);
        wb(0, REG_STATUS, 0);
        check("status_hs", sts(1, 0, 0, 2), rd);
        check("irq_hs", 32'h1, {31'h0, interrupt_request_out});
        repeat (IDLE + 100) @(posedge clk);
        check("chirp_activity", {31'h0, SEL_HS}, {31'h0, xcvr.termination_select});
        check("mon_j", {30'h0, LINE_J}, {30'h0, line_state_monitor});
        $display("test hs host done");
        host_mode <= 2'h3;
        repeat (10) @(negedge clk);
        check("mon_se0", {30'h0, LINE_SE0}, {30'h0, line_state_monitor});
        wait_for(4, IDLE + 50);
        check("revert", 1, n + 10 >= IDLE && n + 10 <= IDLE + 10);
        wait_for(0, SAMPLE + 20);
        check("sample", 1, n >= SAMPLE - 2 && n <= SAMPLE + 10);
        wait_for(1, CHIRP + 10);
        host_mode <= 2'h0;
        wb(1, REG_CONTROL, 32'h27);
        repeat (3) @(posedge clk);
        wb(0, REG_STATUS, 0);
        check("restart", 32'h0, rd & 32'h70);
        check("restart_sel", {31'h0, SEL_FS}, {31'h0, xcvr.transceiver_speed_select});
        $display("test revert done");
        end_of_test();
    end
endmodule : usb_hs_chirp_handshake_test
